// ==== pkg/shpmc_defs.vh ====
`ifndef SHPMC_DEFS_VH
`define SHPMC_DEFS_VH

// register offsets (4-bit index)
`define SHPMC_ADDR_W          4
`define SHPMC_REG_MODE        4'h0
`define SHPMC_REG_PERIPH_EN   4'h1
`define SHPMC_REG_KEEP_EN     4'h2
`define SHPMC_REG_RESET_FLAGS 4'h3
`define SHPMC_REG_CMD         4'h4

// keep-alive enable fields
`define SHPMC_KEEP_WDOSC      0
`define SHPMC_KEEP_WDT        1
`define SHPMC_KEEP_AMP        2
`define SHPMC_KEEP_WDT_RESET  3

// reset cause flag fields
`define SHPMC_FLAG_WDT        0
`define SHPMC_FLAG_STOP       1

// command register bits
`define SHPMC_CMD_CLR_FLAGS   0

// reset values
`define SHPMC_PERIPH_EN_RST   8'hFF
`define SHPMC_KEEP_EN_RST     8'h03

// power modes
`define SHPMC_MODE_ACTIVE     2'h0
`define SHPMC_MODE_HALT       2'h1
`define SHPMC_MODE_STOP       2'h2
`define SHPMC_MODE_WAKE       2'h3

// oscillator restart settle time before core resumes
`define SHPMC_OSC_SETTLE_NS   64
`define SHPMC_CLK_PERIOD_NS   4
`define SHPMC_OSC_SETTLE_CYC  ((`SHPMC_OSC_SETTLE_NS + \
                                `SHPMC_CLK_PERIOD_NS - 1) / \
                               `SHPMC_CLK_PERIOD_NS)

`endif

// ==== hw/shpmc_wake_timer.v ====
`include "shpmc_defs.vh"

// counts oscillator settle cycles after a wake request
module shpmc_wake_timer #(
    parameter CYCLES = `SHPMC_OSC_SETTLE_CYC,
    parameter CNT_W  = 8
) (
    input  wire clk,
    input  wire resetn,
    input  wire start,
    output reg  done_ff
);

    reg [CNT_W-1:0] cnt_ff;
    reg             run_ff;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff  <= {CNT_W{1'b0}};
            run_ff  <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start) begin
                cnt_ff <= {CNT_W{1'b0}};
                run_ff <= 1'b1;
            end else if (run_ff) begin
                if (cnt_ff == CYCLES[CNT_W-1:0] - 1'b1) begin
                    run_ff  <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    end

endmodule

// ==== hw/shpmc_power_ctrl.v ====
// What this block does
// - stop instruction enters STOP; all off but brownout, amp, watchdog
// - brownout, amplifier and watchdog can each be disabled too
// - STOP halts crystal and precision oscillators; crystal pins to GPIO
// - STOP halts the system clock
// - STOP freezes the program counter
// - watchdog RC oscillator runs in STOP when its enable is set
// - enabled watchdog logic keeps counting in STOP only while the watchdog RC oscillator enable is also set
// - brownout runs in STOP only when its option bit allows
// - amplifier runs in STOP only if its enable allows
// - all other peripherals idle during STOP
// - HALT powers down only the core
// - Active is neither STOP nor HALT; peripherals individually disabled
// - STOP is left only through stop mode recovery
// - watchdog reset timeout in STOP: recovery, watchdog and stop flags
//
// Chosen here: the plain strobed port and the placing of the registers.
`include "shpmc_defs.vh"

module shpmc_power_ctrl #(
    parameter NUM_PERIPH = 8
) (
    input  wire                     clk,
    input  wire                     resetn,
    input  wire [`SHPMC_ADDR_W-1:0] regAddr,
    input  wire [7:0]               regWrData,
    input  wire                     regWr,
    input  wire                     regRd,
    output reg  [7:0]               regRdData_ff,
    input  wire                     stopInstr,
    input  wire                     haltInstr,
    input  wire                     wakeEvent,
    input  wire                     wdtTimeout,
    input  wire                     brownoutStopOpt,
    input  wire                     crystalPinsEn,
    output reg  [1:0]               powerMode_ff,
    output reg                      primaryOscEn_ff,
    output reg                      precisionOscEn_ff,
    output reg                      crystalPinsOwn_ff,
    output reg                      sysClkEn_ff,
    output reg                      coreRun_ff,
    output reg                      pcAdvanceEn_ff,
    output reg                      wdtOscEn_ff,
    output reg                      wdtLogicEn_ff,
    output reg                      brownoutEn_ff,
    output reg                      ampEn_ff,
    output reg  [NUM_PERIPH-1:0]    periphEn_ff,
    output reg  [1:0]               reset_cause_flags_ff
);

    // ------------------------------------------------------------
    // mode encodings
    // ------------------------------------------------------------
    localparam [1:0] ST_ACTIVE = `SHPMC_MODE_ACTIVE;
    localparam [1:0] ST_HALT   = `SHPMC_MODE_HALT;
    localparam [1:0] ST_STOP   = `SHPMC_MODE_STOP;
    localparam [1:0] ST_WAKE   = `SHPMC_MODE_WAKE;

    // ------------------------------------------------------------
    // state and software registers
    // ------------------------------------------------------------
    reg [1:0]            mode_ff;
    reg [1:0]            nxt_mode;
    reg [7:0]            periphCfg_ff;
    reg [7:0]            keepCfg_ff;
    reg                  wakeStart;
    wire                 wakeDone;

    wire inStop    = (mode_ff == ST_STOP);
    wire wdtLive   = keepCfg_ff[`SHPMC_KEEP_WDT];
    wire wdtRstCfg = keepCfg_ff[`SHPMC_KEEP_WDT_RESET];
    wire wdtWake   = inStop && wdtLive && wdtRstCfg && wdtTimeout;

    // ------------------------------------------------------------
    // oscillator settle timer
    // ------------------------------------------------------------
    shpmc_wake_timer #(
        .CYCLES (`SHPMC_OSC_SETTLE_CYC),
        .CNT_W  (8)
    ) u_wake_timer (
        .clk     (clk),
        .resetn  (resetn),
        .start   (wakeStart),
        .done_ff (wakeDone)
    );

    // ------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------
    always @* begin
        nxt_mode  = mode_ff;
        wakeStart = 1'b0;
        case (mode_ff)
            ST_ACTIVE: begin
                if (stopInstr) begin
                    nxt_mode = ST_STOP;
                end else if (haltInstr) begin
                    nxt_mode = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wakeEvent) begin
                    nxt_mode = ST_ACTIVE;
                end
            end
            ST_STOP: begin
                if (wakeEvent || wdtWake) begin
                    nxt_mode  = ST_WAKE;
                    wakeStart = 1'b1;
                end
            end
            ST_WAKE: begin
                if (wakeDone) begin
                    nxt_mode = ST_ACTIVE;
                end
            end
            default: begin
                nxt_mode = ST_ACTIVE;
            end
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_ff <= ST_ACTIVE;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            periphCfg_ff <= `SHPMC_PERIPH_EN_RST;
            keepCfg_ff   <= `SHPMC_KEEP_EN_RST;
        end else if (regWr) begin
            if (regAddr == `SHPMC_REG_PERIPH_EN) begin
                periphCfg_ff <= regWrData;
            end
            if (regAddr == `SHPMC_REG_KEEP_EN) begin
                keepCfg_ff <= regWrData;
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reset_cause_flags_ff <= 2'h0;
        end else if (wdtWake) begin
            reset_cause_flags_ff <= 2'h3;
        end else if (regWr && regAddr == `SHPMC_REG_CMD &&
                     regWrData[`SHPMC_CMD_CLR_FLAGS]) begin
            reset_cause_flags_ff <= 2'h0;
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdData_ff <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                `SHPMC_REG_MODE:        regRdData_ff <= {6'h00, mode_ff};
                `SHPMC_REG_PERIPH_EN:   regRdData_ff <= periphCfg_ff;
                `SHPMC_REG_KEEP_EN:     regRdData_ff <= keepCfg_ff;
                `SHPMC_REG_RESET_FLAGS: begin
                    regRdData_ff <= {6'h00, reset_cause_flags_ff};
                end
                default:                regRdData_ff <= 8'h00;
            endcase
        end else begin
            regRdData_ff <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // power enables, driven from next mode; watchdog and amplifier enables from keep-alive bits only
    // ------------------------------------------------------------
    wire nxtStop   = (nxt_mode == ST_STOP);
    wire nxtActive = (nxt_mode == ST_ACTIVE);
    wire nxtClocks = !nxtStop;

    reg  nxt_primaryOscEn;
    reg  nxt_precisionOscEn;
    reg  nxt_crystalPinsOwn;
    reg  nxt_sysClkEn;
    reg  nxt_coreRun;
    reg  nxt_pcAdvanceEn;
    reg  nxt_wdtOscEn;
    reg  nxt_wdtLogicEn;
    reg  nxt_brownoutEn;
    reg  nxt_ampEn;

    always @* begin
        // oscillators off, pins back to gpio
        nxt_primaryOscEn   = nxtClocks;
        nxt_precisionOscEn = nxtClocks;
        nxt_crystalPinsOwn = nxtClocks && crystalPinsEn;
        nxt_sysClkEn       = nxtClocks;
        nxt_coreRun        = nxtActive;
        nxt_pcAdvanceEn    = nxtActive;
        nxt_wdtOscEn       = keepCfg_ff[`SHPMC_KEEP_WDOSC];
        nxt_wdtLogicEn     = wdtLive && keepCfg_ff[`SHPMC_KEEP_WDOSC];
        nxt_brownoutEn     = nxtClocks || brownoutStopOpt;
        nxt_ampEn          = keepCfg_ff[`SHPMC_KEEP_AMP];
    end

    // ------------------------------------------------------------
    // mode, oscillator and clock outputs
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            powerMode_ff      <= ST_ACTIVE;
            primaryOscEn_ff   <= 1'b1;
            precisionOscEn_ff <= 1'b1;
            crystalPinsOwn_ff <= 1'b0;
            sysClkEn_ff       <= 1'b1;
        end else begin
            powerMode_ff      <= nxt_mode;
            primaryOscEn_ff   <= nxt_primaryOscEn;
            precisionOscEn_ff <= nxt_precisionOscEn;
            crystalPinsOwn_ff <= nxt_crystalPinsOwn;
            sysClkEn_ff       <= nxt_sysClkEn;
        end
    end

    // ------------------------------------------------------------
    // core outputs
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            coreRun_ff     <= 1'b1;
            pcAdvanceEn_ff <= 1'b1;
        end else begin
            coreRun_ff     <= nxt_coreRun;
            pcAdvanceEn_ff <= nxt_pcAdvanceEn;
        end
    end

    // ------------------------------------------------------------
    // keep-alive outputs
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdtOscEn_ff   <= 1'b0;
            wdtLogicEn_ff <= 1'b0;
            brownoutEn_ff <= 1'b1;
            ampEn_ff      <= 1'b0;
        end else begin
            wdtOscEn_ff   <= nxt_wdtOscEn;
            wdtLogicEn_ff <= nxt_wdtLogicEn;
            brownoutEn_ff <= nxt_brownoutEn;
            ampEn_ff      <= nxt_ampEn;
        end
    end

    // ------------------------------------------------------------
    // peripheral enables, one flip-flop per block
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi = gi + 1) begin : g_periph
            // idle in stop, gated in active/halt
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    periphEn_ff[gi] <= 1'b0;
                end else begin
                    periphEn_ff[gi] <= nxtClocks && periphCfg_ff[gi];
                end
            end
        end
    endgenerate

endmodule

// ==== tb/shpmc_core_model.sv ====
// processor core side: issues stop and halt instructions
module shpmc_core_model (
    input  wire logic clk,
    input  wire logic coreRun,
    output logic      stopInstr,
    output logic      haltInstr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {stopInstr, haltInstr} = 2'h0;
    // instructions only execute while the core runs
    task automatic exec(input logic isStop);
        while (coreRun !== 1'b1) @(posedge clk);
        @(posedge clk);
        stopInstr <= isStop;
        haltInstr <= !isStop;
        @(posedge clk);
        {stopInstr, haltInstr} <= 2'h0;
        #1;
    endtask
endmodule

// ==== tb/shpmc_power_ctrl_chk.sv ====
module shpmc_power_ctrl_chk #(
    parameter NUM_PERIPH = 8
) (
    input wire logic                  clk,
    input wire logic                  resetn,
    input wire logic                  stopInstr,
    input wire logic                  haltInstr,
    input wire logic                  wakeEvent,
    input wire logic                  wdtTimeout,
    input wire logic                  brownoutStopOpt,
    input wire logic [1:0]            powerMode_ff,
    input wire logic                  primaryOscEn_ff,
    input wire logic                  crystalPinsOwn_ff,
    input wire logic                  sysClkEn_ff,
    input wire logic                  coreRun_ff,
    input wire logic                  pcAdvanceEn_ff,
    input wire logic                  brownoutEn_ff,
    input wire logic [NUM_PERIPH-1:0] periphEn_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_stop_entry: assert property (powerMode_ff == 2'h0 && stopInstr
        |=> powerMode_ff == 2'h2) else $error("stop not entered");
    a_clk_halted: assert property (powerMode_ff == 2'h2
        |-> !sysClkEn_ff && !primaryOscEn_ff && !crystalPinsOwn_ff)
        else $error("clock or oscillator running in stop");
    a_core_idle: assert property (powerMode_ff != 2'h0
        |-> !coreRun_ff && !pcAdvanceEn_ff) else $error("core runs");
    a_periph_idle: assert property (powerMode_ff == 2'h2
        |-> periphEn_ff == '0) else $error("peripheral awake in stop");
    a_brownout_opt: assert property (powerMode_ff == 2'h2
        && $past(powerMode_ff) == 2'h2
        |-> brownoutEn_ff == $past(brownoutStopOpt))
        else $error("brownout ignores option bit");
    a_halt_entry: assert property (powerMode_ff == 2'h0 && haltInstr
        && !stopInstr |=> powerMode_ff == 2'h1 && sysClkEn_ff)
        else $error("halt entry wrong");
    a_halt_exit: assert property (powerMode_ff == 2'h1 && wakeEvent
        |=> powerMode_ff == 2'h0) else $error("halt wake wrong");
    a_stop_hold: assert property (powerMode_ff == 2'h2 && !wakeEvent
        && !wdtTimeout |=> powerMode_ff == 2'h2)
        else $error("stop left without recovery");
    a_wake_order: assert property (powerMode_ff == 2'h2 && wakeEvent
        |=> (powerMode_ff == 2'h3 && sysClkEn_ff && !coreRun_ff)[*8]
        ##10 (powerMode_ff == 2'h0 && coreRun_ff))
        else $error("recovery order wrong");
endmodule

// ==== tb/shpmc_power_ctrl_tb.sv ====
`include "shpmc_defs.vh"

module shpmc_power_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, resetn, regWr, regRd, wakeEvent, wdtTimeout;
    logic       brownoutStopOpt, crystalPinsEn, stopInstr, haltInstr;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData_ff, periphEn_ff;
    logic [1:0] powerMode_ff, reset_cause_flags_ff;
    logic       primaryOscEn_ff, precisionOscEn_ff, crystalPinsOwn_ff;
    logic       sysClkEn_ff, coreRun_ff, pcAdvanceEn_ff, wdtOscEn_ff;
    logic       wdtLogicEn_ff, brownoutEn_ff, ampEn_ff;
    int         errors = 0, checkCount = 0, cyc = 0;
    wire  [7:0] enSig = {primaryOscEn_ff, precisionOscEn_ff,
        crystalPinsOwn_ff, sysClkEn_ff, coreRun_ff, pcAdvanceEn_ff,
        wdtOscEn_ff, wdtLogicEn_ff};
    wire  [7:0] auxSig = {2'h0, reset_cause_flags_ff, brownoutEn_ff,
        ampEn_ff, powerMode_ff};
    shpmc_power_ctrl shpmc_power_ctrl_i (.clk, .resetn, .regAddr,
        .regWrData, .regWr, .regRd, .regRdData_ff, .stopInstr, .haltInstr,
        .wakeEvent, .wdtTimeout, .brownoutStopOpt, .crystalPinsEn,
        .powerMode_ff, .primaryOscEn_ff, .precisionOscEn_ff,
        .crystalPinsOwn_ff, .sysClkEn_ff, .coreRun_ff, .pcAdvanceEn_ff,
        .wdtOscEn_ff, .wdtLogicEn_ff, .brownoutEn_ff, .ampEn_ff,
        .periphEn_ff, .reset_cause_flags_ff);
    shpmc_core_model shpmc_core_model_i (.clk, .coreRun(coreRun_ff),
        .stopInstr, .haltInstr);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic finalReport();
        $display("checks %0d errors %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            finalReport();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        {regAddr, regWrData, regWr} <= {a, d, 1'b1};
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        {regAddr, regRd} <= {a, 1'b1};
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdData_ff, exp);
    endtask
    // recovery by wake source or watchdog timeout, then settle count
    task automatic wake(input logic viaWdt);
        int n;
        @(posedge clk);
        {wakeEvent, wdtTimeout} <= {!viaWdt, viaWdt};
        @(posedge clk);
        {wakeEvent, wdtTimeout} <= 2'h0;
        #1 chk({2'h0, enSig[7:2]}, 8'h3C);
        n = 0;
        while (coreRun_ff !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        chk(8'(n), 8'd17);
    endtask
    initial begin
        {regWr, regRd, wakeEvent, wdtTimeout, brownoutStopOpt} = 5'h0;
        {regAddr, regWrData, resetn, crystalPinsEn} = 14'h1;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(`SHPMC_REG_PERIPH_EN, 8'hFF);
        rd(`SHPMC_REG_KEEP_EN, 8'h03);
        rd(`SHPMC_REG_RESET_FLAGS, 8'h00);
        rd(4'hF, 8'h00);
        chk(enSig, 8'hFF);
        wr(`SHPMC_REG_PERIPH_EN, 8'h5A);
        @(posedge clk) #1 chk(periphEn_ff, 8'h5A);
        wr(`SHPMC_REG_MODE, 8'h02);
        chk(auxSig, 8'h08);
        $display("test active done");
        wr(`SHPMC_REG_KEEP_EN, 8'h07);
        shpmc_core_model_i.exec(1'b1);
        chk(enSig, 8'h03);
        chk(auxSig, 8'h06);
        chk(periphEn_ff, 8'h00);
        @(posedge clk) brownoutStopOpt <= 1'b1;
        @(posedge clk) wdtTimeout <= 1'b1;
        @(posedge clk) wdtTimeout <= 1'b0;
        #1 chk(auxSig, 8'h0E);
        wake(1'b0);
        chk(enSig, 8'hFF);
        brownoutStopOpt <= 1'b0;
        $display("test stop done");
        wr(`SHPMC_REG_KEEP_EN, 8'h00);
        shpmc_core_model_i.exec(1'b1);
        chk(enSig, 8'h00);
        chk(auxSig, 8'h02);
        wake(1'b0);
        wr(`SHPMC_REG_KEEP_EN, 8'h0B);
        shpmc_core_model_i.exec(1'b1);
        wake(1'b1);
        chk(auxSig, 8'h38);
        rd(`SHPMC_REG_RESET_FLAGS, 8'h03);
        wr(`SHPMC_REG_CMD, 8'h01);
        rd(`SHPMC_REG_RESET_FLAGS, 8'h00);
        $display("test watchdog done");
        shpmc_core_model_i.exec(1'b0);
        chk(enSig, 8'hF3);
        chk(auxSig, 8'h09);
        chk(periphEn_ff, 8'h5A);
        @(posedge clk) wakeEvent <= 1'b1;
        @(posedge clk) wakeEvent <= 1'b0;
        #1 chk(auxSig, 8'h08);
        @(posedge clk) crystalPinsEn <= 1'b0;
        @(posedge clk) #1 chk(enSig, 8'hDF);
        $display("test halt done");
        finalReport();
    end
endmodule

bind shpmc_power_ctrl shpmc_power_ctrl_chk #(.NUM_PERIPH(NUM_PERIPH))
    shpmc_power_ctrl_chk_i (.clk, .resetn, .stopInstr, .haltInstr,
    .wakeEvent, .wdtTimeout, .brownoutStopOpt, .powerMode_ff,
    .primaryOscEn_ff, .crystalPinsOwn_ff, .sysClkEn_ff, .coreRun_ff,
    .pcAdvanceEn_ff, .brownoutEn_ff, .periphEn_ff);
